/* dpc_pkg.sv */
// Package of constants for the dual-port memory port controller.
package dpc_pkg;
    // Own register offsets (byte addresses on the AHB-Lite bus).
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    // Control register field positions.
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_FLAG = 2;
    localparam int CTRL_OE_IN_WR = 3;
    // Status register field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_COLL = 2;
    localparam int ST_IRQ = 3;
    localparam int ST_FLAG_GRANTED = 4;
    // Mailbox addresses.
    localparam logic [12:0] MBOX_LEFT = 13'h1FFE;
    localparam logic [12:0] MBOX_RIGHT = 13'h1FFF;
    // Timing figures in ns and the cycle counts derived from them.
    localparam int CLK_NS = 25;
    localparam int WP_NS = 20;
    localparam int WZ_NS = 15;
    localparam int DW_NS = 15;
    localparam int WH_NS = 20;
    localparam int ACC_NS = 25;
    localparam int DDD_NS = 55;
    localparam int SWRD_NS = 5;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WZDW_CYC = (WZ_NS + DW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WH_CYC = (WH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int DDD_CYC = (DDD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SWRD_CYC = (SWRD_NS + CLK_NS - 1) / CLK_NS;
    // Cycles for a pin change to pass the three stages and the output flop.
    localparam int SYNC_CYC = 4;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage : dpc_pkg

/* dpc_sync_if.sv */
// Interface carrying raw pin levels into the synchroniser and clean levels out.
interface dpc_sync_if;
    logic busy_n_raw;
    logic irq_n_raw;
    logic busy_n;
    logic irq_n;
    modport sync (input busy_n_raw, input irq_n_raw, output busy_n,
                  output irq_n);
    modport user (output busy_n_raw, output irq_n_raw, input busy_n,
                  input irq_n);
endinterface : dpc_sync_if

/* dpc_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module dpc_sync (
    input wire logic hclk,
    input wire logic hresetn,
    dpc_sync_if.sync s
);
    logic [2:0] busy_q, busy_d;
    logic [2:0] irq_q, irq_d;
    logic busy_out_q, busy_out_d;
    logic irq_out_q, irq_out_d;

    // Shift both pins in; the first stage feeds only the second.
    always_comb begin
        busy_d = {busy_q[1:0], s.busy_n_raw};
        irq_d = {irq_q[1:0], s.irq_n_raw};
        busy_out_d = (busy_q[1] == busy_q[2]) ? busy_q[2] : busy_out_q;
        irq_out_d = (irq_q[1] == irq_q[2]) ? irq_q[2] : irq_out_q;
    end

    // Pins idle high, so reset loads ones.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 3'h7;
            irq_q <= 3'h7;
            busy_out_q <= 1'b1;
            irq_out_q <= 1'b1;
        end else begin
            busy_q <= busy_d;
            irq_q <= irq_d;
            busy_out_q <= busy_out_d;
            irq_out_q <= irq_out_d;
        end
    end

    assign s.busy_n = busy_out_q;
    assign s.irq_n = irq_out_q;
endmodule : dpc_sync

/* dpc_host.sv */
// Host-side port controller driving one port of a two-port memory from AHB-Lite.
//
// Function
// R1: Address changes only while write strobe and port select are both high.
// R2: Memory write happens in overlap of select low and strobe low.
// R3: Select falls no earlier than strobe so device outputs stay off; here select falls a cycle before the strobe.
// R4: Host drives write data only after device outputs are off.
// R5: With output enable low, strobe covers turn-off plus set-up time.
// R6: Flag accesses keep port select high throughout write and read.
// R7: Flag value is seen on all eight data bits.
// R8: A free flag reads as all ones.
// R9: Contended flag goes to exactly one port; software checks readback.
// R10: Master grants the port whose address and select settled first.
// R11: Close accesses still give busy on exactly one side.
// R12: Busy asserts within the access bound after address match.
// R13: Busy asserts within the access bound after late select falls.
// R14: Busy releases within the disable bound on mismatch or deselect.
// R15: Read data is sampled only after the post-busy valid delay.
// R16: In slave role busy is an input; no arbitration set-up applies.
// R17: External busy must lead the strobe to inhibit a contending write.
// R18: Strobe held at least write-hold time after busy releases.
// R19: Far-port data is readable within the port-to-port bound.
// R20: Left write of top address sets right interrupt; right read clears.
// R21: Right write of next address sets left interrupt; left read clears.
// R22: Writes are ignored while busy is driven low for this port.
// R23: Both busy outputs are never low together.
// R24: Eight flags chosen by address bits 0 to 2, written on bit 0.
// R25: Zero takes a free flag; holder's one passes it to waiter.
// R26: Busy low leaves mailbox interrupt flag unchanged.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
module dpc_host #(
    parameter int AW = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic port_select_n,
    output logic flag_space_select_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [AW-1:0] mem_addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic busy_n,
    input wire logic mailbox_irq_n
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD,
                              S_READ, S_GAP} dpc_state_e;

    dpc_sync_if sif ();
    dpc_sync u_sync (.hclk(hclk), .hresetn(hresetn), .s(sif));
    assign sif.busy_n_raw = busy_n; // Busy is only ever an input here. [R16]
    assign sif.irq_n_raw = mailbox_irq_n;

    dpc_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] rdata_q, rdata_d;
    logic done_q, done_d, coll_q, coll_d;
    logic sel_q, sel_d, strobe_q, strobe_d, oe_q, oe_d, doe_q, doe_d;
    logic dph_q, dph_d, dwr_q, dwr_d;
    logic [7:0] dreg_q, dreg_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic go;

    // Slave answers every access with zero wait states.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign go = dph_q && dwr_q && dreg_q == dpc_pkg::REG_CTRL &&
                hwdata[dpc_pkg::CTRL_GO] && st_q == S_IDLE;

    // Bus decode: address phase captured, register effects in data phase.
    always_comb begin
        dph_d = hsel && hready && htrans[1];
        dwr_d = hwrite;
        dreg_d = haddr[7:0];
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        hrdata_d = 32'h0000_0000;
        // Registers load only while idle, so pins never move mid-cycle. [R1]
        if (dph_q && dwr_q && st_q == S_IDLE) begin
            unique case (dreg_q)
                dpc_pkg::REG_CTRL: ctrl_d = hwdata[3:0];
                dpc_pkg::REG_ADDR: addr_d = hwdata[AW-1:0];
                dpc_pkg::REG_WDATA: wdata_d = hwdata[7:0];
                default: ;
            endcase
        end
        if (dph_d && !hwrite) begin
            unique case (haddr[7:0])
                dpc_pkg::REG_CTRL: hrdata_d = {28'h0, ctrl_q};
                dpc_pkg::REG_ADDR: hrdata_d = {{(32-AW){1'b0}}, addr_q};
                dpc_pkg::REG_WDATA: hrdata_d = {24'h0, wdata_q};
                dpc_pkg::REG_STATUS: hrdata_d = {27'h0,
                    ~rdata_q[0], ~sif.irq_n, coll_q, done_q,
                    st_q != S_IDLE};
                dpc_pkg::REG_RDATA: hrdata_d = {24'h0, rdata_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Pin sequencer. The address is only loaded while idle, so it moves
    // only with select and strobe high. [R1]
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        strobe_d = strobe_q;
        oe_d = oe_q;
        doe_d = doe_q;
        rdata_d = rdata_q;
        done_d = done_q;
        coll_d = coll_q;
        if (go)
            done_d = 1'b0;
        unique case (st_q)
            S_IDLE: begin
                if (go) begin
                    // Select asserted a cycle before the strobe. [R3] [R6]
                    sel_d = 1'b1;
                    oe_d = !hwdata[dpc_pkg::CTRL_WRITE] ||
                           hwdata[dpc_pkg::CTRL_OE_IN_WR];
                    cnt_d = dpc_pkg::CNT_ONE;
                    st_d = hwdata[dpc_pkg::CTRL_WRITE] ? S_SETUP : S_READ;
                end
            end
            S_SETUP: begin
                strobe_d = 1'b1; // [R2]
                // Output enable low stretches the pulse. [R5]
                // The pulse also spans the busy delay and the synchroniser,
                // so a collision is seen before the strobe can end. [R17]
                cnt_d = 4'(dpc_pkg::ACC_CYC + dpc_pkg::SYNC_CYC
                    + (oe_q ? dpc_pkg::WZDW_CYC : dpc_pkg::WP_CYC));
                st_d = S_STROBE;
            end
            S_STROBE: begin
                doe_d = 1'b1; // Data only after strobe turned outputs off. [R4]
                if (!sif.busy_n) begin
                    // Write is inhibited while busy; wait it out. [R17] [R22]
                    coll_d = 1'b1;
                    cnt_d = 4'(dpc_pkg::WH_CYC); // [R18]
                end else if (cnt_q <= dpc_pkg::CNT_ONE) begin
                    st_d = S_HOLD;
                end else begin
                    cnt_d = cnt_q - dpc_pkg::CNT_ONE;
                end
            end
            S_HOLD: begin
                // Strobe released first, data held one more cycle.
                strobe_d = 1'b0;
                st_d = S_GAP;
                cnt_d = 4'(dpc_pkg::SWRD_CYC);
            end
            S_READ: begin
                // Busy stalls a read; sample after far-port delay. [R15] [R19]
                if (!sif.busy_n) begin
                    coll_d = 1'b1;
                    cnt_d = 4'(dpc_pkg::DDD_CYC);
                end else if (cnt_q <= dpc_pkg::CNT_ONE) begin
                    rdata_d = data_in; // Flag value on all bits. [R7] [R8]
                    st_d = S_GAP;
                    cnt_d = 4'(dpc_pkg::SWRD_CYC);
                end else begin
                    cnt_d = cnt_q - dpc_pkg::CNT_ONE;
                end
            end
            S_GAP: begin
                sel_d = 1'b0;
                oe_d = 1'b0;
                doe_d = 1'b0;
                if (cnt_q <= dpc_pkg::CNT_ONE) begin
                    st_d = S_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - dpc_pkg::CNT_ONE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        if (st_q == S_IDLE && go && !hwdata[dpc_pkg::CTRL_WRITE])
            // Reads wait until a busy answer has cleared the synchroniser.
            cnt_d = 4'(dpc_pkg::ACC_CYC + dpc_pkg::SYNC_CYC);
    end

    // Pins derive from registers; flag space picks one of two selects.
    // Flag writes carry the bit on data bit 0 and flag address in bits 2:0.
    assign port_select_n = !(sel_q && !ctrl_q[dpc_pkg::CTRL_FLAG]);
    assign flag_space_select_n = !(sel_q && ctrl_q[dpc_pkg::CTRL_FLAG]);
    assign write_strobe_n = !strobe_q; // [R24] [R25]
    assign output_enable_n = !oe_q;
    assign mem_addr = addr_q;
    assign data_out = wdata_q;
    assign data_oe = doe_q;

    // Registers; select and strobe reset high on the pins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 4'h0;
            ctrl_q <= 4'h0;
            addr_q <= '0;
            wdata_q <= 8'h00;
            rdata_q <= 8'hFF;
            done_q <= 1'b0;
            coll_q <= 1'b0;
            sel_q <= 1'b0;
            strobe_q <= 1'b0;
            oe_q <= 1'b0;
            doe_q <= 1'b0;
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            dreg_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            coll_q <= coll_d;
            sel_q <= sel_d;
            strobe_q <= strobe_d;
            oe_q <= oe_d;
            doe_q <= doe_d;
            dph_q <= dph_d;
            dwr_q <= dwr_d;
            dreg_q <= dreg_d;
            hrdata_q <= hrdata_d;
        end
    end
endmodule : dpc_host

/* dpc_host_chk.sv */
// Checker of port-side write, flag and reset behaviour of the host controller.
module dpc_host_chk #(
    parameter int AW = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic port_select_n,
    input wire logic flag_space_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [AW-1:0] mem_addr,
    input wire logic data_oe,
    input wire logic busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sel;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Either select counts, so flag cycles are covered too.
    assign sel = !(port_select_n && flag_space_select_n);
    // A write cycle begins where the strobe falls.
    sequence s_wr_start;
        $fell(write_strobe_n);
    endsequence
    chk_addr_steady: assert property (!write_strobe_n && sel |-> $stable(mem_addr))
        else $error("address moved inside a write");
    chk_wr_needs_sel: assert property (!write_strobe_n |-> sel)
        else $error("strobe low without a select");
    chk_sel_leads_wr: assert property (s_wr_start |-> $past(sel))
        else $error("select fell with or after the strobe");
    chk_drive_in_wr: assert property ($rose(data_oe) |-> !write_strobe_n)
        else $error("data driven before the strobe");
    chk_drive_sel: assert property (data_oe |-> sel)
        else $error("data driven outside a cycle");
    chk_oe_wr_width: assert property (
        s_wr_start ##0 !output_enable_n |-> !write_strobe_n [*2])
        else $error("strobe too short with outputs on");
    chk_flag_no_ce: assert property (!flag_space_select_n |-> port_select_n)
        else $error("memory select low in a flag cycle");
    chk_hold_busy: assert property (
        $rose(busy_n) && !write_strobe_n |=> !write_strobe_n)
        else $error("strobe released too soon after busy");
    chk_reset_idle: assert property ($rose(hresetn) |-> !data_oe && sel == 0
        && write_strobe_n && output_enable_n)
        else $error("pins not idle after reset");
endmodule : dpc_host_chk

bind dpc_host dpc_host_chk #(.AW(AW)) u_dpc_host_chk (.hclk(hclk),
    .hresetn(hresetn), .port_select_n(port_select_n),
    .flag_space_select_n(flag_space_select_n), .busy_n(busy_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .mem_addr(mem_addr), .data_oe(data_oe));

/* dpc_dev_model.sv */
// Behavioural model of one memory port, far port steered by the bench.
module dpc_dev_model (
    input wire logic port_select_n,
    input wire logic flag_space_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [12:0] mem_addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic far_busy,
    input wire logic [7:0] far_hold,
    input wire logic far_post,
    output logic [7:0] data_wire,
    output logic busy_n,
    output logic mailbox_irq_n,
    output logic far_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [8192];
    logic [7:0] own = 8'h00;
    logic [7:0] junk = 8'hA5;
    logic drv;
    // Released pins wander, so a stale value never passes for read data.
    initial forever #13 junk = {junk[6:0], ~junk[7]};
    // Only this port ever loses, so both sides are never busy.
    assign busy_n = !(far_busy && !port_select_n);
    // Outputs turn on while output enable and a select are low, never once the strobe is low.
    assign drv = !output_enable_n && write_strobe_n
        && !(port_select_n && flag_space_select_n);
    // A flag reads on all eight bits; a free flag reads ones.
    always_comb begin
        if (data_oe) data_wire = data_out;
        else if (drv && !flag_space_select_n) data_wire = {8{~own[mem_addr[2:0]]}};
        else if (drv) data_wire = mem[mem_addr];
        else data_wire = junk;
    end
    // Writes land at strobe end, dropped while busy; far holder wins.
    always @(posedge write_strobe_n) begin
        if (!port_select_n && busy_n) mem[mem_addr] = data_wire;
        // Our write of the top mailbox raises the far side's flag.
        if (!port_select_n && busy_n && mem_addr == dpc_pkg::MBOX_RIGHT)
            far_irq_n = 1'h0;
        if (!flag_space_select_n && data_wire[0]) own[mem_addr[2:0]] = 1'h0;
        else if (!flag_space_select_n && !far_hold[mem_addr[2:0]])
            own[mem_addr[2:0]] = 1'h1;
    end
    // A far post raises our flag; an unbusy mailbox read clears it.
    initial mailbox_irq_n = 1'h1;
    initial far_irq_n = 1'h1;
    always @(posedge far_post) mailbox_irq_n = 1'h0;
    always @(*) if (drv && !port_select_n && busy_n
        && mem_addr == dpc_pkg::MBOX_LEFT) mailbox_irq_n = 1'h1;
endmodule : dpc_dev_model

/* tb_dual_port_ram_arbitration.sv */
// Self-checking bench of the host controller against the memory model.
module tb_dual_port_ram_arbitration;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] v; logic [31:0] m;} dpc_note_s;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, chk_rd, dph;
    logic [31:0] haddr, hwdata, hrdata, seed, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ce_n, sem_n, we_n, oe_n, doe, busy_n, irq_n, far_busy, far_post;
    logic far_irq_n;
    logic [12:0] maddr;
    logic [7:0] dout, dwire, far_hold;
    dpc_note_s exp_q[$];
    dpc_note_s n;
    int miscompares, samples_checked, cyc, i;
    assign hready = hreadyout;
    dpc_host u_dpc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .port_select_n(ce_n),
        .flag_space_select_n(sem_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .mem_addr(maddr), .data_in(dwire),
        .data_out(dout), .data_oe(doe), .busy_n(busy_n),
        .mailbox_irq_n(irq_n));
    dpc_dev_model u_dpc_dev_model (.port_select_n(ce_n),
        .flag_space_select_n(sem_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .mem_addr(maddr), .data_out(dout),
        .data_oe(doe), .far_busy(far_busy), .far_hold(far_hold),
        .far_post(far_post), .data_wire(dwire), .busy_n(busy_n),
        .mailbox_irq_n(irq_n), .far_irq_n(far_irq_n));
    initial begin
        hclk = 1'h0;
        forever #12.5 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : check
    task automatic test_done();
        $display("Counts: %0d mismatches in %0d checks", miscompares,
            samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // One single transfer; a checked read notes its expected word first.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic c, input logic [31:0] m,
        output logic [31:0] rd);
        hsel <= 1'h1; haddr <= {24'h0, a}; htrans <= 2'h2;
        hwrite <= w; hsize <= 3'h2; chk_rd <= c;
        if (c) exp_q.push_back('{d, m});
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask : bus
    // Loads address, data and control, then polls until done.
    task automatic op(input logic [3:0] ctl, input logic [12:0] a,
        input logic [7:0] d);
        logic [31:0] q;
        bus(1'h1, dpc_pkg::REG_ADDR, {19'h0, a}, 1'h0, 32'h0, q);
        bus(1'h1, dpc_pkg::REG_WDATA, {24'h0, d}, 1'h0, 32'h0, q);
        bus(1'h1, dpc_pkg::REG_CTRL, {28'h0, ctl}, 1'h0, 32'h0, q);
        do bus(1'h0, dpc_pkg::REG_STATUS, 32'h0, 1'h0, 32'h0, q);
        while (q[dpc_pkg::ST_DONE] !== 1'h1);
    endtask : op
    // Takes the oldest note whenever a checked read completes.
    always @(posedge hclk) begin
        if (dph && hready === 1'h1) begin
            n = exp_q.pop_front();
            check(hrdata & n.m, n.v & n.m);
        end
        if (hready === 1'h1) dph <= hsel && htrans[1] && !hwrite && chk_rd;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        hresetn = 1'h0; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'h0; hsize = 3'h2; hwdata = 32'h0; chk_rd = 1'h0;
        dph = 1'h0; far_busy = 1'h0; far_hold = 8'h20; far_post = 1'h0;
        cyc = 0; seed = 32'h0FAFDF46;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, 8'h14, 32'h0, 1'h1, 32'hFFFFFFFF, r);
        // Random words, odd passes with outputs enabled in the write.
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            op(i[0] ? 4'hB : 4'h3, {1'h0, seed[11:0]}, seed[23:16]);
            op(4'h1, {1'h0, seed[11:0]}, 8'h0);
            bus(1'h0, dpc_pkg::REG_RDATA, {24'h0, seed[23:16]}, 1'h1, 32'hFF, r);
        end
        // Every flag taken and freed; the far side holds flag five.
        for (i = 0; i < 8; i++) begin
            op(4'h7, i[12:0], 8'h00);
            op(4'h5, i[12:0], 8'h0);
            bus(1'h0, dpc_pkg::REG_RDATA, i == 5 ? 32'hFF : 32'h0, 1'h1, 32'hFF, r);
            op(4'h7, i[12:0], 8'h01);
            op(4'h5, i[12:0], 8'h0);
            bus(1'h0, dpc_pkg::REG_RDATA, 32'hFF, 1'h1, 32'hFF, r);
        end
        // A far post is seen, then cleared by reading our mailbox.
        far_post <= 1'h1;
        repeat (6) @(posedge hclk);
        far_post <= 1'h0;
        bus(1'h0, dpc_pkg::REG_STATUS, 32'h8, 1'h1, 32'h8, r);
        op(4'h1, dpc_pkg::MBOX_LEFT, 8'h0);
        repeat (6) @(posedge hclk);
        bus(1'h0, dpc_pkg::REG_STATUS, 32'h0, 1'h1, 32'h8, r);
        // Contention stalls a write, which completes once busy clears.
        far_busy <= 1'h1;
        fork
            op(4'h3, 13'h0123, 8'h5A);
            begin
                repeat (12) @(posedge hclk);
                far_busy <= 1'h0;
            end
        join
        bus(1'h0, dpc_pkg::REG_STATUS, 32'h4, 1'h1, 32'h4, r);
        op(4'h1, 13'h0123, 8'h0);
        bus(1'h0, dpc_pkg::REG_RDATA, 32'h5A, 1'h1, 32'hFF, r);
        // Writing the top mailbox posts to the far side.
        check({31'h0, far_irq_n}, 32'h1);
        op(4'h3, dpc_pkg::MBOX_RIGHT, 8'h3C);
        check({31'h0, far_irq_n}, 32'h0);
        repeat (2) @(posedge hclk);
        test_done();
    end
endmodule : tb_dual_port_ram_arbitration
